/* eep_write_host.sv */
// Host controller that unlocks, page-loads and polls a protected parallel EEPROM
// Overview of operation
// - Every write operation, even one byte, starts with the unlock sequence.
// - After unlock, one to 64 bytes are loaded and programmed together.
// - The three unlock writes use their exact full addresses.
// - All loaded bytes carry the same page number on address bits 6 to 12.
// - Output enable is high whenever write strobe and chip select are low.
// - Each byte load starts within 100 us of the previous one.
// - Polling reads all use one fixed address.
`timescale 1ns/1ps
`default_nettype none
module eep_write_host
  import eep_pkg::*;
#(
  parameter int unsigned PAGE_MAX = PAGE_BYTES,
  parameter int unsigned BLC_CYCLES = BLC_CYC,
  parameter int unsigned WC_CYCLES = WC_CYC,
  parameter logic [12:0] UNLOCK_ADDR0 = UNLOCK_A0,
  parameter logic [12:0] UNLOCK_ADDR1 = UNLOCK_A1,
  parameter logic [12:0] UNLOCK_ADDR2 = UNLOCK_A2,
  parameter logic [7:0] UNLOCK_DATA0 = UNLOCK_D0,
  parameter logic [7:0] UNLOCK_DATA1 = UNLOCK_D1,
  parameter logic [7:0] UNLOCK_DATA2 = UNLOCK_D2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command: start a page write of cmd_count bytes (1..64)
  input wire logic cmd_start,
  input wire logic [12:0] cmd_page_addr,
  input wire logic [6:0] cmd_count,
  output logic cmd_busy,
  // Byte stream: one byte offered per request
  input wire logic byte_valid,
  input wire logic [5:0] byte_offset,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  // Completion
  output logic op_done,
  output logic [1:0] op_result,
  // Device pins
  output logic [12:0] eep_addr,
  output logic [7:0] eep_dout,
  output logic eep_doe_n,
  input wire logic [7:0] eep_din,
  output logic eep_ce_n,
  output logic eep_oe_n,
  output logic eep_we_n
);
  typedef enum {HS_IDLE, HS_UNLOCK, HS_WAIT_BYTE, HS_LOAD, HS_POLL_RD,
                HS_POLL_CHK, HS_DONE} eep_hs_t;
  // Wait budget that keeps falling write strobes less than one load window apart
  localparam int unsigned LOAD_WIN = BLC_CYCLES - WP_CYC - WPH_CYC - HS_OVH_CYC;
  eep_bus_if bus ();
  eep_hs_t state, next_state;
  logic [1:0] ustep, next_ustep;
  logic [6:0] left, next_left;
  logic [6:0] page_hi, next_page_hi;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [12:0] last_addr, next_last_addr;
  logic [7:0] last_data, next_last_data;
  logic have_prev, next_have_prev;
  logic [7:0] prev_rd, next_prev_rd;
  logic next_busy, next_ready, next_done;
  logic [1:0] next_result;
  logic req, next_req, is_wr, next_is_wr;
  logic [12:0] raddr, next_raddr;
  logic [7:0] wdat, next_wdat;

  function automatic logic [12:0] unlock_addr(input logic [1:0] s);
    case (s)
      2'h0: unlock_addr = UNLOCK_ADDR0;
      2'h1: unlock_addr = UNLOCK_ADDR1;
      default: unlock_addr = UNLOCK_ADDR2;
    endcase
  endfunction

  function automatic logic [7:0] unlock_data(input logic [1:0] s);
    case (s)
      2'h0: unlock_data = UNLOCK_DATA0;
      2'h1: unlock_data = UNLOCK_DATA1;
      default: unlock_data = UNLOCK_DATA2;
    endcase
  endfunction

  assign bus.req = req;
  assign bus.is_write = is_wr;
  assign bus.addr = raddr;
  assign bus.wdata = wdat;

  eep_pin_cycle u_pins (
    .clk(clk),
    .rst(rst),
    .bus(bus.slave),
    .pin_addr(eep_addr),
    .pin_dout(eep_dout),
    .pin_doe_n(eep_doe_n),
    .pin_din(eep_din),
    .pin_ce_n(eep_ce_n),
    .pin_oe_n(eep_oe_n),
    .pin_we_n(eep_we_n)
  );

  always_comb begin
    next_state = state;
    next_ustep = ustep;
    next_left = left;
    next_page_hi = page_hi;
    next_tmr = tmr;
    next_last_addr = last_addr;
    next_last_data = last_data;
    next_have_prev = have_prev;
    next_prev_rd = prev_rd;
    next_busy = cmd_busy;
    next_ready = 1'b0;
    next_done = 1'b0;
    next_result = op_result;
    next_req = 1'b0;
    next_is_wr = is_wr;
    next_raddr = raddr;
    next_wdat = wdat;
    // Load window and program timer share one counter
    if (tmr != '0) begin
      next_tmr = tmr - 1'b1;
    end
    case (state)
      HS_IDLE: begin
        if (cmd_start && cmd_count != 7'h00 && cmd_count <= 7'(PAGE_MAX)) begin
          next_busy = 1'b1;
          next_left = cmd_count;
          next_page_hi = cmd_page_addr[12:PAGE_LSB];
          next_ustep = 2'h0;
          // Each operation begins with a fresh unlock
          next_state = HS_UNLOCK;
          next_req = 1'b1;
          next_is_wr = 1'b1;
          next_raddr = unlock_addr(2'h0);
          next_wdat = unlock_data(2'h0);
        end
      end
      HS_UNLOCK: begin
        if (bus.done) begin
          if (ustep == 2'h2) begin
            next_tmr = TMR_W'(LOAD_WIN);
            next_ready = 1'b1;
            next_state = HS_WAIT_BYTE;
          end else begin
            next_ustep = ustep + 2'h1;
            next_req = 1'b1;
            next_raddr = unlock_addr(ustep + 2'h1);
            next_wdat = unlock_data(ustep + 2'h1);
          end
        end
      end
      HS_WAIT_BYTE: begin
        next_ready = 1'b1;
        if (byte_valid && byte_ready) begin
          next_ready = 1'b0;
          next_req = 1'b1;
          next_is_wr = 1'b1;
          next_raddr = {page_hi, byte_offset};
          next_wdat = byte_data;
          next_last_addr = {page_hi, byte_offset};
          next_last_data = byte_data;
          next_state = HS_LOAD;
        end else if (tmr == '0) begin
          // Window lapsed: device programs what it has, so start polling
          next_result = RES_TIMEOUT;
          next_ready = 1'b0;
          next_tmr = TMR_W'(WC_CYCLES);
          next_have_prev = 1'b0;
          next_state = HS_POLL_RD;
        end
      end
      HS_LOAD: begin
        if (bus.done) begin
          next_left = left - 7'h1;
          if (left == 7'h1) begin
            next_tmr = TMR_W'(WC_CYCLES);
            next_have_prev = 1'b0;
            next_state = HS_POLL_RD;
          end else begin
            // Window restarts on each load; margin covers the strobe cycle
            next_tmr = TMR_W'(LOAD_WIN);
            next_ready = 1'b1;
            next_state = HS_WAIT_BYTE;
          end
        end
      end
      HS_POLL_RD: begin
        // Fixed poll address: the last loaded location
        next_req = 1'b1;
        next_is_wr = 1'b0;
        next_raddr = last_addr;
        next_state = HS_POLL_CHK;
      end
      HS_POLL_CHK: begin
        if (bus.done) begin
          next_prev_rd = bus.rdata;
          next_have_prev = 1'b1;
          // Finished when toggle line stops and poll line shows true data
          if (have_prev && (bus.rdata[6] == prev_rd[6])
              && (bus.rdata[7] == last_data[7])) begin
            if (bus.rdata != last_data && op_result == RES_OK) begin
              next_result = RES_MISMATCH;
            end
            next_state = HS_DONE;
          end else if (tmr == '0) begin
            next_result = RES_TIMEOUT;
            next_state = HS_DONE;
          end else begin
            next_state = HS_POLL_RD;
          end
        end
      end
      HS_DONE: begin
        next_done = 1'b1;
        next_busy = 1'b0;
        next_state = HS_IDLE;
      end
      default: next_state = HS_IDLE;
    endcase
    if (state == HS_IDLE && cmd_start) begin
      next_result = RES_OK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= HS_IDLE;
      ustep <= 2'h0;
      left <= 7'h00;
      page_hi <= 7'h00;
      tmr <= '0;
      last_addr <= 13'h0000;
      last_data <= 8'h00;
      have_prev <= 1'b0;
      prev_rd <= 8'h00;
      cmd_busy <= 1'b0;
      byte_ready <= 1'b0;
      op_done <= 1'b0;
      op_result <= RES_OK;
      req <= 1'b0;
      is_wr <= 1'b0;
      raddr <= 13'h0000;
      wdat <= 8'h00;
    end else begin
      state <= next_state;
      ustep <= next_ustep;
      left <= next_left;
      page_hi <= next_page_hi;
      tmr <= next_tmr;
      last_addr <= next_last_addr;
      last_data <= next_last_data;
      have_prev <= next_have_prev;
      prev_rd <= next_prev_rd;
      cmd_busy <= next_busy;
      byte_ready <= next_ready;
      op_done <= next_done;
      op_result <= next_result;
      req <= next_req;
      is_wr <= next_is_wr;
      raddr <= next_raddr;
      wdat <= next_wdat;
    end
  end
endmodule : eep_write_host
`default_nettype wire

/* eep_pkg.sv */
// Package with timing constants and command defaults for the EEPROM write host
`default_nettype none
package eep_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PAGE_BYTES = 64;
  localparam int unsigned PAGE_LSB = 6;
  // Write strobe low time, least 200 ns
  localparam int unsigned WP_NS = 200;
  localparam int unsigned WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe high time between writes, least 100 ns
  localparam int unsigned WPH_NS = 100;
  localparam int unsigned WPH_CYC = (WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Read access time, most 200 ns; sample after it
  localparam int unsigned ACC_NS = 200;
  localparam int unsigned ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  // Output enable high pulse between polls, least 150 ns
  localparam int unsigned OEHP_NS = 150;
  localparam int unsigned OEHP_CYC = (OEHP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Byte load window, at most 100 us
  localparam int unsigned BLC_US = 100;
  localparam int unsigned BLC_CYC = BLC_US * (CLK_HZ / 1000000);
  // Program cycle time, at most 10 ms
  localparam int unsigned WC_MS = 10;
  localparam int unsigned WC_CYC = WC_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W = 20;
  // Cycles from the end of a strobe cycle to the next falling strobe: done, react, request, launch
  localparam int unsigned HS_OVH_CYC = 4;
  localparam logic [12:0] UNLOCK_A0 = 13'h1555;
  localparam logic [12:0] UNLOCK_A1 = 13'h0aaa;
  localparam logic [12:0] UNLOCK_A2 = 13'h1555;
  localparam logic [7:0] UNLOCK_D0 = 8'haa;
  localparam logic [7:0] UNLOCK_D1 = 8'h55;
  localparam logic [7:0] UNLOCK_D2 = 8'ha0;
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_TIMEOUT = 2'h1;
  localparam logic [1:0] RES_MISMATCH = 2'h2;
endpackage : eep_pkg
`default_nettype wire

/* eep_bus_if.sv */
// Interface carrying pin requests between the sequencer and the pin driver
`timescale 1ns/1ps
`default_nettype none
interface eep_bus_if;
  logic req;
  logic is_write;
  logic [12:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport master (output req, output is_write, output addr, output wdata,
                  input done, input rdata);
  modport slave (input req, input is_write, input addr, input wdata,
                 output done, output rdata);
endinterface : eep_bus_if
`default_nettype wire

/* eep_pin_cycle.sv */
// Single write or read strobe cycle on the EEPROM pins
`timescale 1ns/1ps
`default_nettype none
module eep_pin_cycle
  import eep_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request side
  eep_bus_if.slave bus,
  // Pins
  output logic [12:0] pin_addr,
  output logic [7:0] pin_dout,
  output logic pin_doe_n,
  input wire logic [7:0] pin_din,
  output logic pin_ce_n,
  output logic pin_oe_n,
  output logic pin_we_n
);
  typedef enum {PC_IDLE, PC_LOW, PC_HIGH} eep_pc_t;
  eep_pc_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [12:0] next_addr;
  logic [7:0] next_dout, next_rdata;
  logic next_doe_n, next_ce_n, next_oe_n, next_we_n, next_done;
  logic wr;
  logic next_wr;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_addr = pin_addr;
    next_dout = pin_dout;
    next_doe_n = pin_doe_n;
    next_ce_n = pin_ce_n;
    next_oe_n = pin_oe_n;
    next_we_n = pin_we_n;
    next_rdata = bus.rdata;
    next_done = 1'b0;
    next_wr = wr;
    case (state)
      PC_IDLE: begin
        if (bus.req) begin
          next_addr = bus.addr;
          next_dout = bus.wdata;
          next_wr = bus.is_write;
          next_doe_n = ~bus.is_write;
          next_ce_n = 1'b0;
          // Output enable stays high for the whole write strobe
          next_oe_n = bus.is_write;
          next_we_n = ~bus.is_write;
          next_cnt = bus.is_write ? 4'(WP_CYC - 1) : 4'(ACC_CYC - 1);
          next_state = PC_LOW;
        end
      end
      PC_LOW: begin
        if (cnt == 4'h0) begin
          // Data latches on the rising strobe edge; data held one more cycle
          next_we_n = 1'b1;
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_rdata = pin_din;
          next_cnt = wr ? 4'(WPH_CYC - 1) : 4'(OEHP_CYC - 1);
          next_state = PC_HIGH;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      PC_HIGH: begin
        next_doe_n = 1'b1;
        if (cnt == 4'h0) begin
          next_done = 1'b1;
          next_state = PC_IDLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      default: next_state = PC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= PC_IDLE;
      cnt <= 4'h0;
      pin_addr <= 13'h0000;
      pin_dout <= 8'h00;
      pin_doe_n <= 1'b1;
      pin_ce_n <= 1'b1;
      pin_oe_n <= 1'b1;
      pin_we_n <= 1'b1;
      bus.rdata <= 8'h00;
      bus.done <= 1'b0;
      wr <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pin_addr <= next_addr;
      pin_dout <= next_dout;
      pin_doe_n <= next_doe_n;
      pin_ce_n <= next_ce_n;
      pin_oe_n <= next_oe_n;
      pin_we_n <= next_we_n;
      bus.rdata <= next_rdata;
      bus.done <= next_done;
      wr <= next_wr;
    end
  end
endmodule : eep_pin_cycle
`default_nettype wire

/* eep_write_host_checker.sv */
// Checker for the pin protocol of the EEPROM write host
`timescale 1ns/1ps
`default_nettype none
module eep_write_host_checker
  import eep_pkg::*;
#(
  parameter int unsigned BLC_LIMIT = BLC_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command side
  input wire logic cmd_start,
  input wire logic [12:0] cmd_page_addr,
  input wire logic [6:0] cmd_count,
  input wire logic cmd_busy,
  input wire logic byte_ready,
  // Pins
  input wire logic [12:0] eep_addr,
  input wire logic [7:0] eep_dout,
  input wire logic eep_doe_n,
  input wire logic eep_ce_n,
  input wire logic eep_oe_n,
  input wire logic eep_we_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] nwr, next_nwr;
  logic [6:0] pg, next_pg;
  logic [12:0] paddr, next_paddr;
  logic polled, next_polled, we_q, oe_q;
  logic take;
  logic [19:0] gap, next_gap;
  // Cycles since the last falling write strobe, saturating
  always_comb begin
    next_gap = (gap == 20'hfffff) ? gap : gap + 20'h00001;
    if (we_q && !eep_we_n) next_gap = 20'h00000;
  end
  always_ff @(posedge clk) begin
    if (rst) gap <= 20'h00000;
    else gap <= next_gap;
  end
  assign take = cmd_start && !cmd_busy && cmd_count != 7'h00 && cmd_count <= 7'h40;
  always_comb begin
    next_nwr = nwr;
    next_pg = pg;
    next_paddr = paddr;
    next_polled = polled;
    if (take) begin
      next_nwr = 8'h00;
      next_pg = cmd_page_addr[12:6];
      next_polled = 1'b0;
    end else begin
      if (we_q && !eep_we_n) next_nwr = nwr + 8'h01;
      if (oe_q && !eep_oe_n) begin
        next_polled = 1'b1;
        next_paddr = eep_addr;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      {nwr, pg, paddr, polled, we_q, oe_q} <= {8'h00, 7'h00, 13'h0000, 1'b0, 1'b1, 1'b1};
    end else begin
      {nwr, pg, paddr, polled} <= {next_nwr, next_pg, next_paddr, next_polled};
      {we_q, oe_q} <= {eep_we_n, eep_oe_n};
    end
  end
  oe_hi_write_a: assert property ((!eep_we_n && !eep_ce_n) |-> eep_oe_n)
    else $error("output enable low during write strobe");
  no_contend_a: assert property (!eep_oe_n |-> (eep_doe_n && eep_we_n))
    else $error("read strobe while driving data");
  unlock_addr_a: assert property ((we_q && !eep_we_n && nwr < 8'h03) |->
    eep_addr == (nwr == 8'h00 ? UNLOCK_A0 : nwr == 8'h01 ? UNLOCK_A1 : UNLOCK_A2))
    else $error("wrong unlock address");
  unlock_data_a: assert property ((!we_q && eep_we_n && nwr inside {[1:3]}) |->
    $past(eep_dout) == (nwr == 8'h01 ? UNLOCK_D0 : nwr == 8'h02 ? UNLOCK_D1 : UNLOCK_D2))
    else $error("wrong unlock data");
  same_page_a: assert property ((we_q && !eep_we_n && nwr > 8'h02) |-> eep_addr[12:6] == pg)
    else $error("load outside the page");
  poll_addr_a: assert property ((oe_q && !eep_oe_n && polled) |-> eep_addr == paddr)
    else $error("poll address moved");
  load_bound_a: assert property (cmd_busy |-> nwr <= 8'h43)
    else $error("too many loads");
  ready_busy_a: assert property (byte_ready |-> cmd_busy)
    else $error("byte ready while idle");
  load_window_a: assert property ((we_q && !eep_we_n && nwr != 8'h00) |->
    gap < 20'(BLC_LIMIT))
    else $error("byte load window exceeded");
endmodule // eep_write_host_checker
bind eep_write_host eep_write_host_checker #(.BLC_LIMIT(BLC_CYCLES))
  u_chk (.clk(clk), .rst(rst), .cmd_start(cmd_start),
  .cmd_page_addr(cmd_page_addr), .cmd_count(cmd_count), .cmd_busy(cmd_busy),
  .byte_ready(byte_ready), .eep_addr(eep_addr), .eep_dout(eep_dout), .eep_doe_n(eep_doe_n),
  .eep_ce_n(eep_ce_n), .eep_oe_n(eep_oe_n), .eep_we_n(eep_we_n));
`default_nettype wire

/* eep_dev_model.sv */
// Behavioural model of the protected page-write EEPROM
`timescale 1ns/1ps
`default_nettype none
module eep_dev_model
  import eep_pkg::*;
#(
  parameter int WC = 1500,
  parameter int BLC = 200
) (
  input wire logic clk,
  input wire logic [12:0] addr,
  input wire logic [7:0] dout,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [7:0] din
);
  localparam logic [12:0] UA [3] = '{UNLOCK_A0, UNLOCK_A1, UNLOCK_A2};
  localparam logic [7:0] UD [3] = '{UNLOCK_D0, UNLOCK_D1, UNLOCK_D2};
  logic [7:0] mem [8192];
  logic [7:0] pbuf [64];
  logic [63:0] pvld = '0;
  logic [12:0] wa = '0;
  logic [7:0] ld = '0, rd = '0;
  logic [1:0] step = 2'h0;
  logic wr_q = 1'b0, rd_q = 1'b0, tog = 1'b0, loading = 1'b0;
  int blc = 0, prog = 0;
  wire wr = !we_n && !ce_n && oe_n;
  wire rda = !ce_n && !oe_n && we_n;
  initial foreach (mem[i]) mem[i] = 8'hff;
  always @(posedge clk) begin
    wr_q <= wr;
    rd_q <= rda;
    if (rda) rd <= din;
    if (wr && !wr_q) wa <= addr;
    if (loading) blc <= blc + 1;
    if (loading && (blc >= BLC || (rda && !rd_q))) begin
      loading <= 1'b0;
      prog <= WC;
    end
    if (rda && !rd_q && prog > 0) tog <= ~tog;
    if (prog > 0) prog <= prog - 1;
    if (prog == 1) begin
      foreach (pbuf[i]) if (pvld[i]) mem[{wa[12:6], 6'(i)}] <= pbuf[i];
      pvld <= '0;
    end
    if (!wr && wr_q && prog == 0) begin
      if (loading || step == 2'h3) begin
        loading <= 1'b1;
        step <= 2'h0;
        pbuf[wa[5:0]] <= dout;
        pvld[wa[5:0]] <= 1'b1;
        ld <= dout;
        blc <= 0;
      end else if (wa == UA[step] && dout == UD[step]) begin
        step <= step + 2'h1;
      end else begin
        step <= 2'h0;
        prog <= WC;
      end
    end
  end
  // Released lines show the complement of the last read value, never the last one
  always_comb begin
    if (!rda) din = ~rd;
    else if (prog > 0) din = {~ld[7], tog, ld[5:0]};
    else din = mem[addr];
  end
endmodule // eep_dev_model
`default_nettype wire

/* eep_write_host_tb.sv */
// Self-checking testbench of the EEPROM write host
`timescale 1ns/1ps
`default_nettype none
module eep_write_host_tb
  import eep_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, cmd_start = 1'b0, byte_valid = 1'b0;
  logic [12:0] cmd_page_addr = '0;
  logic [6:0] cmd_count = '0;
  logic [5:0] byte_offset = '0;
  logic [7:0] byte_data = '0, eep_din, eep_dout;
  logic [12:0] eep_addr;
  logic cmd_busy, byte_ready, op_done, eep_doe_n, eep_ce_n, eep_oe_n, eep_we_n;
  logic [1:0] op_result;
  int n_mismatch = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  eep_write_host #(.BLC_CYCLES(200), .WC_CYCLES(2000)) u_dut (.clk(clk), .rst(rst),
    .cmd_start(cmd_start), .cmd_page_addr(cmd_page_addr), .cmd_count(cmd_count),
    .cmd_busy(cmd_busy), .byte_valid(byte_valid), .byte_offset(byte_offset),
    .byte_data(byte_data), .byte_ready(byte_ready), .op_done(op_done), .op_result(op_result),
    .eep_addr(eep_addr), .eep_dout(eep_dout), .eep_doe_n(eep_doe_n), .eep_din(eep_din),
    .eep_ce_n(eep_ce_n), .eep_oe_n(eep_oe_n), .eep_we_n(eep_we_n));
  eep_dev_model u_dev (.clk(clk), .addr(eep_addr), .dout(eep_dout), .ce_n(eep_ce_n),
    .oe_n(eep_oe_n), .we_n(eep_we_n), .din(eep_din));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [7:0] data_of(input logic [6:0] pg, input int i);
    return 8'(pg * 5 + i * 37 + 1);
  endfunction
  // Offers feed of cnt bytes, then waits for completion
  task automatic page_write(input logic [6:0] pg, input int cnt, input int feed,
                            output logic [1:0] res);
    int w;
    @(posedge clk);
    cmd_start <= 1'b1;
    cmd_page_addr <= {pg, 6'h00};
    cmd_count <= 7'(cnt);
    @(posedge clk);
    cmd_start <= 1'b0;
    for (int i = 0; i < feed; i++) begin
      byte_valid <= 1'b1;
      byte_offset <= 6'(i);
      byte_data <= data_of(pg, i);
      w = 0;
      do begin @(posedge clk); w++; end while (byte_ready !== 1'b1 && w < 3000);
      if (w >= 3000) n_mismatch++;
    end
    byte_valid <= 1'b0;
    w = 0;
    do begin @(posedge clk); w++; end while (op_done !== 1'b1 && w < 20000);
    if (w >= 20000) n_mismatch++;
    res = op_result;
  endtask
  task automatic s_bad;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      cmd_start <= 1'b1;
      cmd_count <= k == 0 ? 7'h00 : 7'h41;
      @(posedge clk);
      cmd_start <= 1'b0;
      repeat (3) @(posedge clk);
      check(cmd_busy, 1'b0);
    end
  endtask
  task automatic s_single;
    logic [1:0] r;
    page_write(7'h05, 1, 1, r);
    check(r, RES_OK);
    page_write(7'h06, 1, 1, r);
    check(r, RES_OK);
    check(u_dev.mem[13'h0140], data_of(7'h05, 0));
    check(u_dev.mem[13'h0180], data_of(7'h06, 0));
    check(u_dev.mem[UNLOCK_A0], 8'hff);
    check(u_dev.mem[UNLOCK_A1], 8'hff);
  endtask
  task automatic s_page;
    logic [1:0] r;
    page_write(7'h21, 64, 64, r);
    check(r, RES_OK);
    for (int i = 0; i < 64; i++) check(u_dev.mem[{7'h21, 6'(i)}], data_of(7'h21, i));
  endtask
  task automatic s_stall;
    logic [1:0] r;
    page_write(7'h32, 8, 3, r);
    check(r, RES_TIMEOUT);
    repeat (2000) @(posedge clk);
    for (int i = 0; i < 4; i++)
      check(u_dev.mem[{7'h32, 6'(i)}], i < 3 ? data_of(7'h32, i) : 8'hff);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    s_bad;
    s_single;
    s_page;
    s_stall;
    print_verdict;
  end
  // Whole run needs some 10000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end
endmodule // eep_write_host_tb
`default_nettype wire
